// ==== irq_unit_defs.svh ====
`ifndef IRQ_UNIT_DEFS_SVH
`define IRQ_UNIT_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_ENABLE_SET      12'h100
`define OFS_ENABLE_CLR      12'h180
`define OFS_PENDING_SET     12'h200
`define OFS_PENDING_CLEAR   12'h280
`define OFS_PRIORITY_BASE   12'h400
`define OFS_PRIORITY_LAST   12'h41c
`define OFS_ACTIVE          12'h300
`define OFS_TYPE            12'h380
`define OFS_EVT_STATUS      12'h500
`define OFS_EVT_MASK        12'h504

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define NUM_IRQ             32
`define PRIO_HI_BIT         7
`define PRIO_LO_BIT         6
`define RST_WORD            32'h0000_0000
`define HSIZE_WORD          3'h2
`define EVT_OVERRUN_BIT     0
`define EVT_TAKE_BIT        1

`endif

// ==== irq_unit_pkg.sv ====
package irq_unit_pkg;

  typedef logic [31:0] word_t;
  typedef logic [1:0]  prio_t;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_phase_e;

endpackage

// ==== vectored_irq_unit.sv ====
`timescale 1ns/100ps
`include "irq_unit_defs.svh"

// Overview of operation
// [R1] Writing one to pending_clear_bits clears pending; zero ignored; read shows pending.
// [R2] A pending-clear write never alters the active state.
// [R3] One 8-bit priority field per interrupt, four to each 32-bit word.
// [R4] Priority registers accept only full word accesses.
// [R5] Only priority bits 7:6 are stored; bits 5:0 read zero.
// [R6] Priority 0 to 192; smaller value means more urgent.
// [R7] Interrupt M lives in priority word M/4, byte lane M mod 4.
// [R8] Request lines are sampled on the clock edge; pulses latch pending.
// [R9] Peripherals hold a pulse for at least one full clock cycle.
// [R10] Pending on line high while inactive, rising edge, or software set.
// [R11] Service entry clears pending and sets active.
// [R12] Level return: line high makes it pending again, else inactive.
// [R13] Pulse during service makes pending and active; pending after return.
// [R14] Level pending-clear has no effect while line still high.
// [R15] Pulse pending-clear: pending to inactive, active-pending to active.
// [R16] Disabled interrupts still become pending; enable gates only taking.
// [R17] Bus masters use only naturally aligned register accesses.
// [R18] Enabled pending interrupts are offered to the core by priority.
// [R19] Equal urgency ties go to the lowest interrupt number.
module vectored_irq_unit (
  input  wire logic        core_clk,      // Processor clock
  input  wire logic        reset_n,       // Asynchronous reset, active low
  input  wire logic [31:0] irq_line,      // Peripheral request lines
  input  wire logic [31:0] irq_is_pulse,  // Per-line sensitivity, 1 = pulse
  input  wire logic        isr_enter,     // Core enters service of take_num
  input  wire logic        isr_return,    // Core returns from service of ret_num
  input  wire logic [4:0]  ret_num,       // Interrupt number being returned from
  output logic             take_valid,    // An enabled pending request is offered
  output logic [4:0]       take_num,      // Number of the offered request
  output logic [1:0]       take_prio,     // Priority of the offered request
  output logic             irq_event,     // Level event interrupt
  input  wire logic        hsel,          // AHB select
  input  wire logic [31:0] haddr,         // AHB address
  input  wire logic [1:0]  htrans,        // AHB transfer type
  input  wire logic        hwrite,        // AHB write
  input  wire logic [2:0]  hsize,         // AHB size
  input  wire logic [31:0] hwdata,        // AHB write data
  input  wire logic        hready,        // AHB bus ready
  output logic [31:0]      hrdata,        // AHB read data
  output logic             hreadyout,     // AHB slave ready
  output logic             hresp          // AHB response, always OKAY
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                  pend;
    logic [31:0]                  act;
    logic [31:0]                  ena;
    logic [31:0]                  line_q;
    logic [31:0][1:0]             prio;
    logic [1:0]                   evt_stat;
    logic [1:0]                   evt_mask;
    irq_unit_pkg::bus_phase_e     phase;
    logic [11:0]                  addr;
    logic                         word_ok;
    irq_unit_pkg::word_t          rdata;
  } state_s;

  state_s s_reg;
  state_s s_next;

  function automatic logic is_prio_addr(input logic [11:0] a);
    is_prio_addr = (a >= `OFS_PRIORITY_BASE) && (a <= `OFS_PRIORITY_LAST);
  endfunction

  // Byte lane k of word n holds bits 7:6 of interrupt 4n+k
  function automatic irq_unit_pkg::word_t prio_word(input logic [31:0][1:0] p,
                                                    input logic [2:0] n);
    irq_unit_pkg::word_t w;
    w = `RST_WORD;
    for (int k = 0; k < 4; k++)
    begin
      w[8*k+`PRIO_LO_BIT +: 2] = p[{n, 2'(k)}];  // [R7] [R5]
    end
    prio_word = w;
  endfunction

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [31:0] cand;
  logic        best_v;
  logic [4:0]  best_n;
  logic [1:0]  best_p;

  always_comb
  begin
    cand   = s_reg.pend & s_reg.ena & ~s_reg.act;  // [R18] [R16]
    best_v = 1'b0;
    best_n = 5'h00;
    best_p = 2'h3;
    // Strict less-than walking upward keeps the lowest number on ties
    for (int i = 0; i < `NUM_IRQ; i++)
    begin
      if (cand[i] && (!best_v || s_reg.prio[i] < best_p))  // [R6] [R19]
      begin
        best_v = 1'b1;
        best_n = 5'(i);
        best_p = s_reg.prio[i];
      end
    end
  end

  assign take_valid = best_v;
  assign take_num   = best_n;
  assign take_prio  = best_p;
  assign irq_event  = |(s_reg.evt_stat & s_reg.evt_mask);
  assign hrdata     = s_reg.rdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        wr_en;
  logic [31:0] rise;
  logic [31:0] clr_w;
  logic [31:0] set_w;
  logic [31:0] take_oh;
  logic [31:0] ret_oh;
  logic [31:0] new_req;
  logic [1:0]  evt_set;
  logic [11:0] a_next;

  always_comb
  begin
    s_next  = s_reg;
    wr_en   = s_reg.phase == irq_unit_pkg::BUS_WRITE;
    clr_w   = '0;
    set_w   = '0;
    take_oh = '0;
    ret_oh  = '0;
    evt_set = '0;
    a_next  = haddr[11:0];
    if (wr_en && s_reg.addr == `OFS_PENDING_CLEAR)
      clr_w = hwdata;  // [R1]
    if (wr_en && s_reg.addr == `OFS_PENDING_SET)
      set_w = hwdata;
    if (isr_enter && best_v)
      take_oh[best_n] = 1'b1;
    if (isr_return)
      ret_oh[ret_num] = 1'b1;

    // Line is sampled each edge; a pulse held one cycle is caught
    s_next.line_q = irq_line;  // [R8] [R9]
    rise = irq_line & ~s_reg.line_q;
    // Level lines also request while inactive or while being returned
    new_req = rise | set_w | (irq_line & ~irq_is_pulse & ~s_reg.act)  // [R10]
            | (irq_line & ~irq_is_pulse & ret_oh);  // [R12]
    // Pulses during service stay pending for after return
    new_req = new_req | (rise & s_reg.act);  // [R13]

    // A level line still high keeps pending across a clear
    clr_w = clr_w & ~(irq_line & ~irq_is_pulse);  // [R14] [R15]
    evt_set[`EVT_OVERRUN_BIT] = |(rise & s_reg.pend);
    evt_set[`EVT_TAKE_BIT]    = |take_oh;

    // Setting wins over a pending-clear write in the same cycle; service entry wins over setting
    s_next.pend = ((s_reg.pend & ~clr_w & ~take_oh) | new_req) & ~take_oh;  // [R11]
    // Active changes only on service entry and return
    s_next.act  = (s_reg.act & ~ret_oh) | take_oh;  // [R2] [R11] [R12]

    if (wr_en && s_reg.addr == `OFS_ENABLE_SET)
      s_next.ena = s_reg.ena | hwdata;
    if (wr_en && s_reg.addr == `OFS_ENABLE_CLR)
      s_next.ena = s_reg.ena & ~hwdata;
    if (wr_en && s_reg.word_ok && is_prio_addr(s_reg.addr))  // [R4]
    begin
      for (int k = 0; k < 4; k++)
        s_next.prio[{s_reg.addr[4:2], 2'(k)}] = hwdata[8*k+`PRIO_LO_BIT +: 2];  // [R3] [R5]
    end
    if (wr_en && s_reg.addr == `OFS_EVT_MASK)
      s_next.evt_mask = hwdata[1:0];
    if (wr_en && s_reg.addr == `OFS_EVT_STATUS)
      s_next.evt_stat = s_reg.evt_stat & ~hwdata[1:0];
    s_next.evt_stat = s_next.evt_stat | evt_set;

    // Address phase capture; unaligned addresses fall through to reads of zero
    s_next.phase   = irq_unit_pkg::BUS_IDLE;
    s_next.addr    = a_next;
    s_next.word_ok = (hsize == `HSIZE_WORD) && (haddr[1:0] == 2'b00);  // [R17]
    if (hsel && hready && htrans[1])
      s_next.phase = hwrite ? irq_unit_pkg::BUS_WRITE : irq_unit_pkg::BUS_READ;

    s_next.rdata = `RST_WORD;
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (a_next)
        `OFS_ENABLE_SET, `OFS_ENABLE_CLR:    s_next.rdata = s_next.ena;
        `OFS_PENDING_SET, `OFS_PENDING_CLEAR: s_next.rdata = s_next.pend;  // [R1]
        `OFS_ACTIVE:                          s_next.rdata = s_next.act;
        `OFS_TYPE:                            s_next.rdata = irq_is_pulse;
        `OFS_EVT_STATUS:                      s_next.rdata = {30'h0, s_next.evt_stat};
        `OFS_EVT_MASK:                        s_next.rdata = {30'h0, s_next.evt_mask};
        default:
          if (is_prio_addr(a_next) && s_next.word_ok)
            s_next.rdata = prio_word(s_next.prio, a_next[4:2]);
          else
            s_next.rdata = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg       <= '0;
      s_reg.phase <= irq_unit_pkg::BUS_IDLE;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  clear_keeps_active_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R2]
    (s_reg.phase == irq_unit_pkg::BUS_WRITE && s_reg.addr == `OFS_PENDING_CLEAR
     && !isr_enter && !isr_return) |=> s_reg.act == $past(s_reg.act))
    else $error("pending clear changed active state");

  pulse_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R15]
    (s_reg.phase == irq_unit_pkg::BUS_WRITE && s_reg.addr == `OFS_PENDING_CLEAR
     && hwdata[3] && irq_is_pulse[3] && !(irq_line[3] && !s_reg.line_q[3]))
    |=> !s_reg.pend[3])
    else $error("pulse pending not cleared");

  level_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R14]
    (s_reg.pend[20] && irq_line[20] && !irq_is_pulse[20] && !(isr_enter && take_num == 5'h14))
    |=> s_reg.pend[20])
    else $error("asserted level interrupt lost pending");

  entry_moves_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R11]
    (isr_enter && take_valid) |=> (s_reg.act[$past(take_num)] && !s_reg.pend[$past(take_num)]))
    else $error("service entry did not move to active");

  rise_latched_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R8]
    (irq_line[3] && !s_reg.line_q[3] && !(isr_enter && take_num == 5'h3))
    |=> s_reg.pend[3])
    else $error("rising edge not latched");

  disabled_no_take_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R16]
    take_valid |-> (s_reg.ena[take_num] && s_reg.pend[take_num] && !s_reg.act[take_num]))
    else $error("offered interrupt not enabled and pending");

  prio_low_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R5]
    (s_reg.phase == irq_unit_pkg::BUS_READ && is_prio_addr(s_reg.addr))
    |-> (hrdata & 32'h3f3f_3f3f) == 32'h0000_0000)
    else $error("priority low bits not zero");

  best_urgency_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R6]
    (take_valid && cand[0]) |-> (take_prio <= s_reg.prio[0]
      && (take_prio != s_reg.prio[0] || take_num == 5'h0)))
    else $error("lower urgency or higher number chosen");

  level_return_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R12]
    (isr_return && ret_num == 5'h14 && !irq_is_pulse[20] && irq_line[20]
     && !(isr_enter && take_num == 5'h14)) |=> (s_reg.pend[20] && !s_reg.act[20]))
    else $error("level return did not repend");

  // Line 3 probes the pulse kind and line 20 the level kind
  level_clear_low_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R14]
    (s_reg.phase == irq_unit_pkg::BUS_WRITE && s_reg.addr == `OFS_PENDING_CLEAR
     && hwdata[20] && !irq_is_pulse[20] && !irq_line[20]) |=> !s_reg.pend[20])
    else $error("released level interrupt still pending");

  pulse_clear_active_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R15]
    (s_reg.phase == irq_unit_pkg::BUS_WRITE && s_reg.addr == `OFS_PENDING_CLEAR && hwdata[3]
     && irq_is_pulse[3] && s_reg.act[3] && !(irq_line[3] && !s_reg.line_q[3])
     && !(isr_return && ret_num == 5'h3)) |=> (s_reg.act[3] && !s_reg.pend[3]))
    else $error("pulse clear disturbed active interrupt");

  pulse_in_service_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R13]
    (s_reg.act[3] && irq_is_pulse[3] && irq_line[3] && !s_reg.line_q[3]
     && !(isr_return && ret_num == 5'h3)) |=> (s_reg.pend[3] && s_reg.act[3]))
    else $error("pulse during service not pending and active");

  level_request_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R10]
    (irq_line[20] && !irq_is_pulse[20] && !s_reg.act[20]
     && !(isr_enter && take_valid && take_num == 5'h14)) |=> s_reg.pend[20])
    else $error("asserted idle level interrupt not pending");

  soft_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R10]
    (s_reg.phase == irq_unit_pkg::BUS_WRITE && s_reg.addr == `OFS_PENDING_SET && hwdata[20]
     && !(isr_enter && take_valid && take_num == 5'h14)) |=> s_reg.pend[20])
    else $error("software set did not make pending");

  return_leaves_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R12] [R13]
    (isr_return && !(isr_enter && take_valid && take_num == ret_num))
    |=> !s_reg.act[$past(ret_num)])
    else $error("return left interrupt active");

  active_needs_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R11]
    !(isr_enter && take_valid) |=> (s_reg.act & ~$past(s_reg.act)) == 32'h0000_0000)
    else $error("active set without service entry");

  line_tracks_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R8]
    1'b1 |=> s_reg.line_q == $past(irq_line))
    else $error("request lines not sampled each edge");

  offer_ready_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R18]
    (|(s_reg.pend & s_reg.ena & ~s_reg.act)) |-> take_valid)
    else $error("enabled pending interrupt not offered");

  disabled_held_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R16]
    (s_reg.pend[3] && !s_reg.ena[3]) |-> !(take_valid && take_num == 5'h3))
    else $error("disabled interrupt offered");

  // ----------------------------------------------------------------
  // Register bus checks
  // ----------------------------------------------------------------

  // Read data loads at the address edge, so it is judged in the data phase
  prio_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R3] [R7]
    (s_reg.phase == irq_unit_pkg::BUS_WRITE && s_reg.word_ok
     && s_reg.addr == `OFS_PRIORITY_BASE)
    |=> prio_word(s_reg.prio, 3'h0) == ($past(hwdata) & 32'hc0c0_c0c0))
    else $error("priority word not stored in its lanes");

  narrow_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R4]
    (s_reg.phase == irq_unit_pkg::BUS_WRITE && !s_reg.word_ok && is_prio_addr(s_reg.addr))
    |=> s_reg.prio == $past(s_reg.prio))
    else $error("narrow priority write was stored");

  narrow_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R4]
    (s_reg.phase == irq_unit_pkg::BUS_READ && !s_reg.word_ok && is_prio_addr(s_reg.addr))
    |-> hrdata == 32'h0000_0000)
    else $error("narrow priority read not zero");

  pend_readback_a: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R1]
    (s_reg.phase == irq_unit_pkg::BUS_READ && s_reg.addr == `OFS_PENDING_CLEAR)
    |-> hrdata == s_reg.pend)
    else $error("pending read does not match state");

endmodule

// ==== irq_far_side.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Peripheral request lines and processor core
// ----------------------------------------------------------------
module irq_far_side (
  input  wire logic        core_clk,    // Processor clock
  input  wire logic        take_valid,  // Offer from the controller
  output logic      [31:0] irq_line,    // Request lines
  output logic             isr_enter,   // Service entry strobe
  output logic             isr_return,  // Service return strobe
  output logic      [4:0]  ret_num      // Number returned from
);
  initial
  begin
    irq_line   = 32'h0000_0000;
    isr_enter  = 1'b0;
    isr_return = 1'b0;
    ret_num    = 5'h1f;
  end

  // Held over n edges so the controller cannot miss it
  task pulse(input int k, input int n);
    @(posedge core_clk);
    irq_line[k] <= 1'b1;
    repeat (n) @(posedge core_clk);
    irq_line[k] <= 1'b0;
  endtask

  task level(input int k, input logic v);
    @(posedge core_clk);
    irq_line[k] <= v;
  endtask

  // A real core only takes what is offered
  task enter();
    @(posedge core_clk);
    isr_enter <= take_valid;
    @(posedge core_clk);
    isr_enter <= 1'b0;
  endtask

  // Number is scrambled once the strobe is gone
  task ret(input logic [4:0] k);
    @(posedge core_clk);
    isr_return <= 1'b1;
    ret_num    <= k;
    @(posedge core_clk);
    isr_return <= 1'b0;
    ret_num    <= ~k;
  endtask
endmodule

// ==== vectored_irq_unit_bench.sv ====
`timescale 1ns/100ps

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module vectored_irq_unit_bench;
  logic        core_clk, reset_n, isr_enter, isr_return, take_valid, irq_event;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [31:0] irq_line, irq_is_pulse, haddr, hwdata, hrdata, w, r;
  logic [4:0]  ret_num, take_num;
  logic [2:0]  hsize;
  logic [1:0]  htrans, take_prio;
  bit   [31:0] m_pend, m_act, m_en, m_evt, m_mask;
  int          m_prio[32];
  int          fails, tests_run, cycles;

  vectored_irq_unit vectored_irq_unit_inst (.core_clk(core_clk), .reset_n(reset_n),
    .irq_line(irq_line), .irq_is_pulse(irq_is_pulse), .isr_enter(isr_enter),
    .isr_return(isr_return), .ret_num(ret_num), .take_valid(take_valid),
    .take_num(take_num), .take_prio(take_prio), .irq_event(irq_event), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  irq_far_side irq_far_side_inst (.core_clk(core_clk), .take_valid(take_valid),
    .irq_line(irq_line), .isr_enter(isr_enter), .isr_return(isr_return),
    .ret_num(ret_num));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic bus(input logic wrt, input logic [11:0] a, input logic [31:0] d,
                     input logic [2:0] sz, output logic [31:0] q);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= wrt;
    hsize  <= sz;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 3'h2, x);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 3'h2, q);
  endtask

  // Strict compare keeps ties on the lowest number
  function automatic int exp_take();
    int b;
    b = -1;
    for (int i = 0; i < 32; i++)
      if (m_pend[i] && m_en[i] && !m_act[i] && (b < 0 || m_prio[i] < m_prio[b]))
        b = i;
    return b;
  endfunction

  function automatic logic [31:0] pw(int n);
    pw = 32'h0;
    for (int k = 0; k < 4; k++)
      pw[8 * k + 6 +: 2] = 2'(m_prio[4 * n + k]);
  endfunction

  task automatic sync();
    logic [31:0] q;
    int          t;
    rd(12'h280, q);
    `CHK("pending", m_pend, q)
    rd(12'h300, q);
    `CHK("active", m_act, q)
    t = exp_take();
    `CHK("take_valid", t >= 0, take_valid)
    if (t >= 0)
    begin
      `CHK("take_num", t[4:0], take_num)
      `CHK("take_prio", 2'(m_prio[t]), take_prio)
    end
    `CHK("irq_event", (m_evt & m_mask) != 0, irq_event)
  endtask

  task automatic take();
    int t;
    t = exp_take();
    irq_far_side_inst.enter();
    m_pend[t] = 1'b0;
    m_act[t]  = 1'b1;
    m_evt[1]  = 1'b1;
  endtask

  initial
  begin
    {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize        = 3'h2;
    irq_is_pulse = 32'h0000_ffff;
    void'($urandom(32'h92db));
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    sync();
    rd(12'h600, r);
    `CHK("unmapped", 32'h0, r)
    // ----------------------------------------------------------------
    // Priority words and refused narrow writes
    // ----------------------------------------------------------------
    for (int n = 0; n < 8; n++)
    begin
      w = $urandom();
      wr(12'h400 + 12'(4 * n), w);
      rd(12'h400 + 12'(4 * n), r);
      `CHK("priority word", w & 32'hc0c0c0c0, r)
      for (int k = 0; k < 4; k++)
        m_prio[4 * n + k] = int'(w[8 * k + 6 +: 2]);
    end
    bus(1'b1, 12'h404, 32'hffff_ffff, 3'h1, r);
    rd(12'h404, r);
    `CHK("halfword write", pw(1), r)
    bus(1'b0, 12'h404, 32'h0, 3'h1, r);
    `CHK("halfword read", 32'h0, r)
    // ----------------------------------------------------------------
    // Disabled pending lines, then service in urgency order
    // ----------------------------------------------------------------
    wr(12'h200, 32'hffff_ffff);
    wr(12'h280, 32'h00f0_00f0);
    m_pend = 32'hff0f_ff0f;
    sync();
    wr(12'h100, 32'hffff_ffff);
    m_en = 32'hffff_ffff;
    while (exp_take() >= 0)
    begin
      sync();
      take();
    end
    for (int k = 0; k < 32; k++)
      if (m_act[k])
        irq_far_side_inst.ret(5'(k));
    m_act = 32'h0;
    sync();
    // ----------------------------------------------------------------
    // Pulse line: events, service, clears
    // ----------------------------------------------------------------
    wr(12'h504, 32'h3);
    m_mask = 32'h3;
    sync();
    wr(12'h500, 32'h3);
    m_evt = 32'h0;
    irq_far_side_inst.pulse(3, 1 + $urandom % 3);
    irq_far_side_inst.pulse(3, 1);
    m_pend[3] = 1'b1;
    m_evt[0]  = 1'b1;
    sync();
    rd(12'h500, r);
    `CHK("event status", m_evt, r)
    take();
    irq_far_side_inst.pulse(3, 1);
    m_pend[3] = 1'b1;
    sync();
    wr(12'h280, 32'h8);
    m_pend[3] = 1'b0;
    sync();
    irq_far_side_inst.pulse(3, 1);
    irq_far_side_inst.ret(5'd3);
    m_pend[3] = 1'b1;
    m_act[3]  = 1'b0;
    sync();
    wr(12'h280, 32'h8);
    m_pend[3] = 1'b0;
    sync();
    // Disabled line still latches a pulse but is never offered
    wr(12'h180, 32'h0000_0008);
    m_en[3] = 1'b0;
    irq_far_side_inst.pulse(3, 1);
    m_pend[3] = 1'b1;
    sync();
    rd(12'h180, r);
    `CHK("enables", m_en, r)
    // ----------------------------------------------------------------
    // Level line: clears while high, return with line high and low
    // ----------------------------------------------------------------
    irq_far_side_inst.level(20, 1'b1);
    m_pend[20] = 1'b1;
    sync();
    wr(12'h280, 32'h0010_0000);
    sync();
    irq_far_side_inst.level(20, 1'b0);
    wr(12'h280, 32'h0010_0000);
    m_pend[20] = 1'b0;
    sync();
    wr(12'h200, 32'h0010_0000);
    m_pend[20] = 1'b1;
    sync();
    take();
    irq_far_side_inst.level(20, 1'b1);
    irq_far_side_inst.ret(5'd20);
    m_act[20]  = 1'b0;
    m_pend[20] = 1'b1;
    sync();
    irq_far_side_inst.level(20, 1'b0);
    take();
    irq_far_side_inst.ret(5'd20);
    m_act[20] = 1'b0;
    sync();
    summarize();
  end
endmodule
